// >>> itmr_interval_timer.sv
// 32-bit interval down-counter with six 16-bit registers
`timescale 1ns/1ps
// Behaviour
// R1 - six 16-bit registers on the slave port
// R2 - fixed period build drops the period registers
// R3 - control writes start and stop the counter
// R4 - control holds irq enable and one-shot or continuous mode
// R5 - status shows running and zero-reached
// R6 - master writes low and high period halves forming the reload
// R7 - count down each clock, reload at zero without idle cycle
// R8 - any snapshot write latches full 32-bit count coherently
// R9 - irq asserted on zero while irq enable set
// R10 - optional pulse output high one cycle per zero
// R11 - watchdog zero pulses unmaskable reset request
// R12 - build timeout is reset value of both period halves
// R13 - without writable period the period stays the build value
// R14 - one count step per system clock
// R15 - timeout converted to smallest cycle count not shorter
// R16 - watchdog leaves reset stopped, start only, never stops
// R17 - watchdog period write reloads count, data ignored
// R18 - without start/stop bits counter runs from reset
// R19 - offsets and bit positions defined in package
// R20 - reset loads counter with period value
module itmr_interval_timer #(
	parameter bit          WRITABLE_PERIOD = 1'b1,
	parameter bit          READABLE_SNAP   = 1'b1,
	parameter bit          START_STOP      = 1'b1,
	parameter bit          PULSE_ENABLE    = 1'b1,
	parameter bit          WATCHDOG        = 1'b0,
	parameter logic [31:0] PERIOD_INIT     = itmr_pkg::PERIOD_RESET
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic [2:0]  address,
	input  wire logic        write,
	input  wire logic        read,
	input  wire logic [15:0] writeData,
	output logic      [15:0] readData,
	output logic             irq,
	output logic             timeoutPulse,
	output logic             resetRequest
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic        wrCtl;
	logic        wrPerLo;
	logic        wrPerHi;
	logic        wrSnap;
	logic        hasStart;
	logic        hasStop;
	logic        hasPeriod;
	logic [15:0] perLo;
	logic [15:0] perHi;
	logic [31:0] period;
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic [31:0] snap_reg;
	logic        run_reg;
	logic        zero_reg;
	logic        irqEn_reg;
	logic        cont_reg;
	logic        hitZero;
	logic        restart;

	assign wrCtl   = write && address == itmr_pkg::OFS_CONTROL;
	assign wrPerLo = write && address == itmr_pkg::OFS_PERIODLO;
	assign wrPerHi = write && address == itmr_pkg::OFS_PERIODHI;
	assign wrSnap  = write && READABLE_SNAP &&
		(address == itmr_pkg::OFS_SNAPLO || address == itmr_pkg::OFS_SNAPHI);
	assign hasStart = START_STOP || WATCHDOG;
	assign hasStop  = START_STOP && !WATCHDOG;
	assign hasPeriod = WRITABLE_PERIOD && !WATCHDOG;

	// ----------------------------------------
	// period registers
	// ----------------------------------------
	generate
		if (WRITABLE_PERIOD && !WATCHDOG) begin : g_period
			itmr_half_reg #(
				.RESET_VALUE (PERIOD_INIT[15:0])
			) uPerLo (
				.sys_clk (sys_clk),
				.reset   (reset),
				.load    (wrPerLo), // see R6
				.dataIn  (writeData),
				.dataOut (perLo)
			); // see R12
			itmr_half_reg #(
				.RESET_VALUE (PERIOD_INIT[31:16])
			) uPerHi (
				.sys_clk (sys_clk),
				.reset   (reset),
				.load    (wrPerHi), // see R6
				.dataIn  (writeData),
				.dataOut (perHi)
			);
		end else begin : g_fixed
			// no storage at all here, just the build constant
			assign perLo = PERIOD_INIT[15:0]; // see R2
			assign perHi = PERIOD_INIT[31:16]; // see R13
		end
	endgenerate
	assign period = {perHi, perLo};

	// ----------------------------------------
	// control
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irqEn_reg <= itmr_pkg::CONTROL_RESET[itmr_pkg::CTL_IRQEN];
			cont_reg  <= itmr_pkg::CONTROL_RESET[itmr_pkg::CTL_CONT];
		end else if (wrCtl) begin
			irqEn_reg <= writeData[itmr_pkg::CTL_IRQEN]; // see R4
			cont_reg  <= writeData[itmr_pkg::CTL_CONT]; // see R4
		end
	end

	// run flag: free-running builds start at reset release
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			run_reg <= 1'b0;
		end else if (!hasStart) begin
			run_reg <= 1'b1; // see R18
		end else if (wrCtl && writeData[itmr_pkg::CTL_START]) begin
			run_reg <= 1'b1; // see R3, R16
		end else if (wrCtl && hasStop && writeData[itmr_pkg::CTL_STOP]) begin
			run_reg <= 1'b0; // see R3
		end else if (hitZero && !cont_reg && !WATCHDOG) begin
			run_reg <= 1'b0; // see R4
		end
	end

	// ----------------------------------------
	// counter
	// ----------------------------------------
	assign hitZero = run_reg && count_reg == 32'h0000_0000;
	assign restart = WATCHDOG && (wrPerLo || wrPerHi); // see R17

	always_comb begin
		count_next = count_reg;
		if (restart || hitZero) begin
			count_next = period; // see R7
		end else if (run_reg) begin
			count_next = count_reg - 32'h0000_0001; // see R7, R14
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			count_reg <= PERIOD_INIT; // see R20
		end else begin
			count_reg <= count_next;
		end
	end

	// ----------------------------------------
	// snapshot and status
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			snap_reg <= itmr_pkg::SNAP_RESET;
		end else if (wrSnap) begin
			snap_reg <= count_reg; // see R8
		end
	end

	// zero flag is sticky; a new zero wins over a status write clearing it
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			zero_reg <= 1'b0;
		end else if (hitZero) begin
			zero_reg <= 1'b1; // see R5
		end else if (write && address == itmr_pkg::OFS_STATUS) begin
			zero_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// read data and outputs
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			readData <= 16'h0000;
		end else if (read) begin
			unique case (address)
				itmr_pkg::OFS_CONTROL:
					readData <= {14'h0000, cont_reg, irqEn_reg};
				itmr_pkg::OFS_STATUS:
					readData <= {14'h0000, run_reg, zero_reg}; // see R5
				itmr_pkg::OFS_PERIODLO:
					readData <= hasPeriod ? perLo : 16'h0000; // see R2
				itmr_pkg::OFS_PERIODHI:
					readData <= hasPeriod ? perHi : 16'h0000;
				itmr_pkg::OFS_SNAPLO:
					readData <= READABLE_SNAP ? snap_reg[15:0] : 16'h0000;
				itmr_pkg::OFS_SNAPHI:
					readData <= READABLE_SNAP ? snap_reg[31:16] : 16'h0000;
				default:
					readData <= 16'h0000; // see R1
			endcase
		end
	end

	// irq holds until the zero flag is cleared or irq is disabled
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= irqEn_reg && (zero_reg || hitZero); // see R9
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			timeoutPulse <= 1'b0;
			resetRequest <= 1'b0;
		end else begin
			timeoutPulse <= PULSE_ENABLE && hitZero; // see R10
			resetRequest <= WATCHDOG && hitZero; // see R11
		end
	end
endmodule

// >>> itmr_pkg.sv
// package of constants for the 32-bit interval timer
package itmr_pkg;
	// register word offsets
	localparam logic [2:0] OFS_CONTROL  = 3'h0; // see R19
	localparam logic [2:0] OFS_STATUS   = 3'h1;
	localparam logic [2:0] OFS_PERIODLO = 3'h2;
	localparam logic [2:0] OFS_PERIODHI = 3'h3;
	localparam logic [2:0] OFS_SNAPLO   = 3'h4;
	localparam logic [2:0] OFS_SNAPHI   = 3'h5;
	// control field positions
	localparam int CTL_IRQEN = 0;
	localparam int CTL_CONT  = 1;
	localparam int CTL_START = 2;
	localparam int CTL_STOP  = 3;
	// status field positions
	localparam int STS_ZERO  = 0;
	localparam int STS_RUN   = 1;
	// reset values
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [31:0] SNAP_RESET    = 32'h0000_0000;
	// timing: clock period and default timeout
	localparam int  CLK_PERIOD_PS   = 10000;
	localparam longint TIMEOUT_US   = 1;
	// smallest cycle count not shorter than the timeout
	localparam longint TIMEOUT_CYCLES =
		(TIMEOUT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS; // see R15
	// reload value is one less than the cycle count
	localparam logic [31:0] PERIOD_RESET = 32'(TIMEOUT_CYCLES - 1);
endpackage

// >>> itmr_half_reg.sv
// one 16-bit register half with load and reset value
`timescale 1ns/1ps
module itmr_half_reg #(
	parameter logic [15:0] RESET_VALUE = 16'h0000
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        load,
	input  wire logic [15:0] dataIn,
	output logic      [15:0] dataOut
);
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dataOut <= RESET_VALUE;
		end else if (load) begin
			dataOut <= dataIn;
		end
	end
endmodule

// >>> itmr_timer_properties.sv
// port assertions for the interval timer
`timescale 1ns/1ps
module itmr_timer_properties #(
	parameter bit WATCHDOG = 1'b0
) (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic [2:0]  address,
	input wire logic        write,
	input wire logic        read,
	input wire logic [15:0] writeData,
	input wire logic [15:0] readData,
	input wire logic        irq,
	input wire logic        timeoutPulse,
	input wire logic        resetRequest
);
	// ----------
	// properties
	// ----------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_rd(logic [2:0] a);
		read && address == a;
	endsequence
	chk_pulse_width: assert property (timeoutPulse |=> !timeoutPulse)
		else $error("pulse too long");
	chk_req_width: assert property (resetRequest |=> !resetRequest)
		else $error("reset request too long");
	chk_req_off: assert property (!WATCHDOG |-> !resetRequest)
		else $error("reset request without watchdog");
	// irq may also rise when enable is written over a set zero flag
	chk_irq_cause: assert property ($rose(irq) |-> timeoutPulse ||
		$past(timeoutPulse) || $past(write) || $past(write, 2))
		else $error("irq without zero");
	chk_irq_drop: assert property ($fell(irq) |->
		$past(write) || $past(write, 2))
		else $error("irq dropped alone");
	chk_read_hold: assert property (!read |=> $stable(readData))
		else $error("read data moved");
	chk_gap_zero: assert property ((s_rd(3'h6) or s_rd(3'h7)) |=>
		readData == 16'h0000)
		else $error("unmapped read not zero");
	chk_ctl_bits: assert property (s_rd(itmr_pkg::OFS_CONTROL) |=>
		readData[15:2] == 14'h0000)
		else $error("control read high bits");
endmodule
bind itmr_interval_timer itmr_timer_properties #(.WATCHDOG(WATCHDOG)) u_props (
	.sys_clk(sys_clk), .reset(reset), .address(address), .write(write),
	.read(read), .writeData(writeData), .readData(readData), .irq(irq),
	.timeoutPulse(timeoutPulse), .resetRequest(resetRequest));

// >>> itmr_master_model.sv
// bus master model for the timer slave port
`timescale 1ns/1ps
module itmr_master_model (
	input  wire logic        sys_clk,
	output logic      [2:0]  address,
	output logic             write,
	output logic             read,
	output logic      [15:0] writeData,
	input  wire logic [15:0] readData
);
	// ------------
	// bus requests
	// ------------
	initial begin
		address = 3'h0;
		write = 1'b0;
		read = 1'b0;
		writeData = 16'h0000;
	end
	// one 16-bit register per call: control, status, period or snapshot half
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk) #1;
		address = a;
		writeData = d;
		write = 1'b1;
		@(posedge sys_clk) #1;
		write = 1'b0;
		// released data must not look valid
		writeData = ~d;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge sys_clk) #1;
		address = a;
		read = 1'b1;
		@(posedge sys_clk) #1;
		read = 1'b0;
		d = readData;
	endtask
endmodule

// >>> testbench.sv
// self-checking bench for the interval timer
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
module testbench;
	// -----
	// setup
	// -----
	localparam logic [31:0] PER = 32'h0000_0010;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [2:0]  address;
	logic        write, read, irq, timeoutPulse, resetRequest;
	logic [15:0] writeData, readData, d;
	logic [2:0]  wdAddress;
	logic        wdWrite, wdRead, wdResetRequest;
	logic [15:0] wdWriteData, wdReadData;
	int          n_errors = 0;
	int          checks_done = 0;
	int          n;
	always #5 sys_clk = ~sys_clk;
	itmr_interval_timer #(.PERIOD_INIT(PER)) i_itmr_interval_timer (
		.sys_clk(sys_clk), .reset(reset), .address(address), .write(write),
		.read(read), .writeData(writeData), .readData(readData), .irq(irq),
		.timeoutPulse(timeoutPulse), .resetRequest(resetRequest));
	itmr_master_model i_m (.sys_clk(sys_clk), .address(address),
		.write(write), .read(read), .writeData(writeData),
		.readData(readData));
	// watchdog build beside the full-featured one
	if (1'b1) begin : g_wd
		itmr_interval_timer #(.PERIOD_INIT(PER), .WATCHDOG(1'b1),
			.WRITABLE_PERIOD(1'b0), .READABLE_SNAP(1'b0),
			.START_STOP(1'b0), .PULSE_ENABLE(1'b0)) i_itmr_interval_timer (
			.sys_clk(sys_clk), .reset(reset), .address(wdAddress),
			.write(wdWrite), .read(wdRead), .writeData(wdWriteData),
			.readData(wdReadData), .irq(), .timeoutPulse(),
			.resetRequest(wdResetRequest));
	end
	itmr_master_model i_w (.sys_clk(sys_clk), .address(wdAddress),
		.write(wdWrite), .read(wdRead), .writeData(wdWriteData),
		.readData(wdReadData));
	// bounded, so a dead counter gives 200
	task automatic waitp(output int c, input bit wd = 1'b0);
		c = 0;
		do begin
			@(posedge sys_clk) #1;
			c++;
		end while ((wd ? wdResetRequest : timeoutPulse) !== 1'b1 &&
			c < 200);
	endtask
	task automatic print_verdict;
		if (n_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#40000;
		n_errors++;
		print_verdict();
	end
	// -----
	// tests
	// -----
	initial begin
		repeat (2) @(posedge sys_clk);
		#1 reset = 1'b0;
		i_m.rd(itmr_pkg::OFS_STATUS, d);
		`CHK(d, 16'h0000)
		i_m.rd(itmr_pkg::OFS_PERIODLO, d);
		`CHK(d, PER[15:0])
		i_m.rd(itmr_pkg::OFS_PERIODHI, d);
		`CHK(d, PER[31:16])
		waitp(n);
		`CHK(n, 200)
		i_m.wr(itmr_pkg::OFS_CONTROL, 16'h0007);
		waitp(n);
		waitp(n);
		`CHK(n, PER + 1)
		`CHK(irq, 1'b1)
		i_m.rd(itmr_pkg::OFS_STATUS, d);
		`CHK(d, 16'h0003)
		i_m.rd(itmr_pkg::OFS_CONTROL, d);
		`CHK(d, 16'h0003)
		i_m.wr(itmr_pkg::OFS_STATUS, 16'h0000);
		i_m.rd(itmr_pkg::OFS_STATUS, d);
		`CHK(d, 16'h0002)
		`CHK(irq, 1'b0)
		i_m.rd(3'h6, d);
		`CHK(d, 16'h0000)
		waitp(n);
		i_m.wr(itmr_pkg::OFS_SNAPHI, 16'h0000);
		i_m.rd(itmr_pkg::OFS_SNAPLO, d);
		`CHK(d, PER[15:0] - 16'h0001)
		i_m.rd(itmr_pkg::OFS_SNAPHI, d);
		`CHK(d, PER[31:16])
		i_m.wr(itmr_pkg::OFS_PERIODLO, 16'h0008);
		i_m.wr(itmr_pkg::OFS_PERIODHI, 16'h0000);
		waitp(n);
		waitp(n);
		`CHK(n, 9)
		i_m.wr(itmr_pkg::OFS_CONTROL, 16'h0008);
		waitp(n);
		`CHK(n, 200)
		i_m.wr(itmr_pkg::OFS_STATUS, 16'h0000);
		i_m.wr(itmr_pkg::OFS_CONTROL, 16'h0005);
		waitp(n);
		i_m.rd(itmr_pkg::OFS_STATUS, d);
		`CHK(d, 16'h0001)
		waitp(n, 1'b1);
		`CHK(n, 200)
		i_w.wr(itmr_pkg::OFS_CONTROL, 16'h0004);
		i_w.wr(itmr_pkg::OFS_CONTROL, 16'h0008);
		i_w.rd(itmr_pkg::OFS_STATUS, d);
		`CHK(d, 16'h0002)
		i_w.rd(itmr_pkg::OFS_PERIODLO, d);
		`CHK(d, 16'h0000)
		i_w.wr(itmr_pkg::OFS_PERIODHI, 16'h0000);
		waitp(n, 1'b1);
		`CHK(n, PER + 1)
		print_verdict();
	end
endmodule
